/* hdl/rscl_latch.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Capture data port straps during reset
// - Pulled-down reads 0, open reads 1
// - Fetch starts at address zero
// - Privileged init ends at end-of-init
// - High byte: clock, address, chip-select, strobe
// - Low byte: bus type, bootstrap loader, adapter, emulation
// - Clock field selects core multiplier
// - Bus field selects boot bus type
// - Bootstrap loader when strap reads 0
// - Adapter mode when strap reads 0
// - Emulation mode when strap reads 0
// - Init software may change startup settings
// - Waits and placement only by software
module rscl_latch
	import rscl_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        sysResetActive,
	input  wire logic [15:0] strapData,
	input  wire logic        fetchAdvance,
	input  wire logic        end_of_init_instruction,
	input  wire logic        swCfgWrite,
	input  wire rscl_cfg_t   swCfgData,
	output var  rscl_cfg_t   startupCfg,
	output var  logic [23:0] fetchAddr,
	output var  logic        privilegedMode,
	output var  logic        coreRunning
);

	logic [15:0] strap_reg;
	logic [15:0] strap_next;
	rscl_cfg_t   cfg_reg;
	rscl_cfg_t   cfg_next;
	rscl_cfg_t   strapCfg;
	rscl_state_t state_reg;
	rscl_state_t state_next;
	logic [23:0] fetch_reg;
	logic [23:0] fetch_next;
	logic        priv_reg;
	logic        priv_next;
	logic        run_reg;
	logic        run_next;
	logic        inReset;
	logic        inInit;
	logic [2:0]  clkField;
	logic [1:0]  addrField;
	logic [1:0]  csField;
	logic [1:0]  busField;
	logic [3:0]  strapMul;
	logic [7:0]  strapAddrMask;
	logic [4:0]  strapCsMask;
	rscl_bus_t   strapBus;

	// Clock field decode
	function automatic logic [3:0] decodeMul(input logic [2:0] f);
		logic [3:0] m;
		m = MUL_X4;
		unique case (f)
			3'h7: m = MUL_X4;
			3'h6: m = MUL_X3;
			3'h5: m = MUL_X2;
			3'h4: m = MUL_X5;
			3'h3: m = MUL_X1;
			3'h2: m = MUL_X1P5;
			3'h1: m = MUL_X0P5;
			3'h0: m = MUL_X2P5;
		endcase
		return m;
	endfunction

	// Address field decode, one mask bit per line A16..A23
	function automatic logic [7:0] decodeAddr(input logic [1:0] f);
		logic [7:0] m;
		m = 8'h00;
		unique case (f)
			2'h3: m = 8'h03;
			2'h2: m = 8'hFF;
			2'h1: m = 8'h00;
			2'h0: m = 8'h0F;
		endcase
		return m;
	endfunction

	// Chip-select field decode, one mask bit per select
	function automatic logic [4:0] decodeCs(input logic [1:0] f);
		logic [4:0] m;
		m = 5'h00;
		unique case (f)
			2'h0: m = 5'h07;
			2'h1: m = 5'h03;
			2'h3: m = 5'h1F;
			2'h2: m = 5'h00;
		endcase
		return m;
	endfunction

	// Sample port levels while reset is held
	assign strap_next = sysResetActive ? strapData : strap_reg;

	// Raw strap fields from the captured word
	assign clkField  = strap_reg[CLK_MSB:CLK_LSB];
	assign addrField = strap_reg[ADDR_MSB:ADDR_LSB];
	assign csField   = strap_reg[CS_MSB:CS_LSB];
	assign busField  = strap_reg[BUS_MSB:BUS_LSB];

	// Field decode into startup settings
	assign strapMul      = decodeMul(clkField);
	assign strapAddrMask = decodeAddr(addrField);
	assign strapCsMask   = decodeCs(csField);
	assign strapBus      = rscl_bus_t'(busField);

	// Decoded configuration assembled by one driver
	assign strapCfg = '{
		clockMulHalf:    strapMul,
		port4AddrMask:   strapAddrMask,
		port6CsMask:     strapCsMask,
		singleWrStrobe:  strap_reg[WRS_BIT],
		bootBus:         strapBus,
		bootstrapLoader: ~strap_reg[BSL_BIT],
		adapterMode:     ~strap_reg[ADP_BIT],
		emulationMode:   ~strap_reg[EMU_BIT]
	};

	// Sequencer: reset, privileged init, normal run
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RESET: if (!sysResetActive) state_next = ST_INIT;
			ST_INIT:  if (end_of_init_instruction) state_next = ST_RUN;
			ST_RUN:   state_next = ST_RUN;
		endcase
		if (sysResetActive)
			state_next = ST_RESET;
	end

	// Phase flags shared by several selections
	assign inReset = (state_reg == ST_RESET);
	assign inInit  = (state_reg == ST_INIT);

	// Strap copy while in reset; software override only in init
	assign cfg_next = inReset ? strapCfg
		: (inInit && swCfgWrite) ? swCfgData
		: cfg_reg;

	// Mode flags follow the next phase
	assign priv_next = (state_next == ST_INIT);
	assign run_next  = (state_next != ST_RESET);

	// Fetch from zero after reset, step on each advance
	assign fetch_next = inReset ? BOOT_ADDR
		: fetchAdvance ? fetch_reg + FETCH_STEP
		: fetch_reg;

	// Straps default to open levels
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			strap_reg <= STRAP_RESET;
		else
			strap_reg <= strap_next;
	end

	// Decoded configuration, cleared under hard reset
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cfg_reg <= '0;
		else
			cfg_reg <= cfg_next;
	end

	// Phase sequencer register
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			state_reg <= ST_RESET;
		else
			state_reg <= state_next;
	end

	// Fetch address, parked at the boot vector
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			fetch_reg <= BOOT_ADDR;
		else
			fetch_reg <= fetch_next;
	end

	// Privileged init flag
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			priv_reg <= 1'b0;
		else
			priv_reg <= priv_next;
	end

	// Run flag registered for a clean output
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			run_reg <= 1'b0;
		else
			run_reg <= run_next;
	end

	assign startupCfg     = cfg_reg;
	assign fetchAddr      = fetch_reg;
	assign privilegedMode = priv_reg;
	assign coreRunning    = run_reg;

endmodule
`default_nettype wire

/* pkg/rscl_pkg.sv */
`default_nettype none
package rscl_pkg;

	// Strap bit positions on the 16-bit data port
	localparam int CLK_MSB   = 15;
	localparam int CLK_LSB   = 13;
	localparam int ADDR_MSB  = 12;
	localparam int ADDR_LSB  = 11;
	localparam int CS_MSB    = 10;
	localparam int CS_LSB    = 9;
	localparam int WRS_BIT   = 8;
	localparam int BUS_MSB   = 7;
	localparam int BUS_LSB   = 6;
	localparam int BSL_BIT   = 5;
	localparam int ADP_BIT   = 1;
	localparam int EMU_BIT   = 0;

	// Reset values: all straps read as open (logic 1)
	localparam logic [15:0] STRAP_RESET = 16'hFFFF;
	localparam logic [23:0] BOOT_ADDR   = 24'h00_0000;
	localparam logic [23:0] FETCH_STEP  = 24'h00_0002;

	// Multiplier in half steps (x2)
	localparam logic [3:0] MUL_X4   = 4'h8;
	localparam logic [3:0] MUL_X3   = 4'h6;
	localparam logic [3:0] MUL_X2   = 4'h4;
	localparam logic [3:0] MUL_X5   = 4'hA;
	localparam logic [3:0] MUL_X1   = 4'h2;
	localparam logic [3:0] MUL_X1P5 = 4'h3;
	localparam logic [3:0] MUL_X0P5 = 4'h1;
	localparam logic [3:0] MUL_X2P5 = 4'h5;

	typedef enum logic [1:0] {
		BUS_8_DEMUX  = 2'h0,
		BUS_8_MUX    = 2'h1,
		BUS_16_DEMUX = 2'h2,
		BUS_16_MUX   = 2'h3
	} rscl_bus_t;

	// Decoded startup configuration
	typedef struct packed {
		logic [3:0] clockMulHalf;   // multiplier times two
		logic [7:0] port4AddrMask;  // 1 = address line A16+i
		logic [4:0] port6CsMask;    // 1 = chip select i
		logic       singleWrStrobe;
		rscl_bus_t  bootBus;
		logic       bootstrapLoader;
		logic       adapterMode;
		logic       emulationMode;
	} rscl_cfg_t;

	typedef enum {ST_RESET, ST_INIT, ST_RUN} rscl_state_t;

endpackage
`default_nettype wire

/* bench/rscl_strap_net.sv */
`timescale 1ns/1ps
`default_nettype none
module rscl_strap_net
(
	input  wire logic [15:0] pullDown,
	output wire logic [15:0] strapData
);
	// Pulled-down pins read 0, open and reserved pins read 1
	assign strapData = ~pullDown | 16'h001C;
endmodule
`default_nettype wire

/* bench/rscl_latch_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module rscl_latch_properties
	import rscl_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        sysResetActive,
	input wire logic        fetchAdvance,
	input wire logic        end_of_init_instruction,
	input wire logic        swCfgWrite,
	input wire rscl_cfg_t   swCfgData,
	input wire rscl_cfg_t   startupCfg,
	input wire logic [23:0] fetchAddr,
	input wire logic        privilegedMode,
	input wire logic        coreRunning
);
	// Startup, init and override sequencing
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_IDLE: assert property (sysResetActive |=> !coreRunning && !privilegedMode)
		else $error("idle");
	AST_BOOT: assert property ($fell(sysResetActive) |=> fetchAddr == BOOT_ADDR
		&& privilegedMode && coreRunning) else $error("boot");
	AST_FETCH: assert property (fetchAdvance && coreRunning && !sysResetActive |=>
		fetchAddr == $past(fetchAddr) + FETCH_STEP) else $error("fetch");
	AST_END_OF_INIT_INSTRUCTION: assert property (end_of_init_instruction && coreRunning && !sysResetActive
		|=> !privilegedMode) else $error("end_of_init_instruction");
	AST_STAY: assert property (privilegedMode && !end_of_init_instruction && !sysResetActive
		|=> privilegedMode) else $error("stay");
	AST_LOCK: assert property (!privilegedMode && coreRunning && !sysResetActive |=>
		!privilegedMode) else $error("lock");
	AST_HOLD: assert property (!sysResetActive && !$past(sysResetActive) && !swCfgWrite
		|=> $stable(startupCfg)) else $error("hold");
	AST_SWCFG: assert property (swCfgWrite && privilegedMode && !sysResetActive |=>
		startupCfg == $past(swCfgData)) else $error("override");
	AST_REFUSE: assert property (swCfgWrite && !privilegedMode && coreRunning && !sysResetActive
		|=> $stable(startupCfg)) else $error("refused override");
endmodule
bind rscl_latch rscl_latch_properties u_props (.*);
`default_nettype wire

/* bench/test_reset_strap_config_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module test_reset_strap_config_latch
	import rscl_pkg::*;
;
	// Decode tables indexed by strap field code
	localparam logic [31:0] MULS = 32'h864A_2315, ADRS = 32'h03FF_000F, CSS = 32'h1F00_0307;
	logic ref_clk = 1'h0, rst = 1'h1, sysResetActive = 1'h1, fetchAdvance = 1'h0;
	logic end_of_init_instruction = 1'h0, swCfgWrite = 1'h0, privilegedMode, coreRunning;
	logic [15:0] pullDown = 16'h0000, p;
	logic [23:0] fetchAddr;
	wire logic [15:0] strapData;
	rscl_cfg_t swCfgData = '0, startupCfg, e, q[$];
	int errCount = 0, nCompared = 0;
	event ev;
	rscl_latch u_dut (.*);
	rscl_strap_net u_net (.pullDown, .strapData);
	// Expected configuration from a strap word
	function automatic rscl_cfg_t ex(logic [15:0] s);
		return '{MULS[4*s[15:13]+:4], ADRS[8*s[12:11]+:8], CSS[8*s[10:9]+:5], s[8],
			rscl_bus_t'(s[7:6]), ~s[5], ~s[1], ~s[0]};
	endfunction
	task automatic check(rscl_cfg_t seen, rscl_cfg_t want);
		nCompared++;
		if (seen !== want)
		begin
			errCount++;
			$display("BAD startupCfg exp %h seen %h", want, seen);
		end
	endtask
	task automatic end_of_test;
		if (errCount == 0 && nCompared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Note an expectation once n edges have landed
	task automatic note(rscl_cfg_t x, int n);
		repeat (n) @(posedge ref_clk);
		#1;
		q.push_back(x);
		->ev;
	endtask
	initial
		forever
			#12.5 ref_clk = ~ref_clk;
	// Result watcher takes the oldest note
	initial
		forever
		begin
			@(ev);
			check(startupCfg, q.pop_front());
		end
	// Hang guard
	initial
	begin
		#20000;
		errCount++;
		end_of_test();
	end
	// Straps, release, override, end of init, refused override
	initial
	begin
		void'($urandom(53));
		note('0, 7);
		@(posedge ref_clk);
		rst <= 1'h0;
		for (int i = 0; i < 8; i++)
		begin
			p = {i[2:0], i[1:0], i[2:1], i[0], i[1:0], 6'($urandom)};
			@(posedge ref_clk);
			pullDown <= p;
			e = ex(~p | 16'h001C);
			note(e, 3);
		end
		@(posedge ref_clk);
		sysResetActive <= 1'h0;
		@(posedge ref_clk);
		pullDown <= ~p;
		fetchAdvance <= 1'h1;
		note(e, 3);
		@(posedge ref_clk);
		fetchAdvance <= 1'h0;
		e = rscl_cfg_t'(23'($urandom));
		swCfgData <= e;
		swCfgWrite <= 1'h1;
		@(posedge ref_clk);
		swCfgWrite <= 1'h0;
		end_of_init_instruction <= 1'h1;
		note(e, 1);
		@(posedge ref_clk);
		end_of_init_instruction <= 1'h0;
		swCfgData <= ~e;
		swCfgWrite <= 1'h1;
		note(e, 2);
		@(posedge ref_clk);
		swCfgWrite <= 1'h0;
		sysResetActive <= 1'h1;
		note(ex(p | 16'h001C), 3);
		@(posedge ref_clk);
		end_of_test();
	end
endmodule
`default_nettype wire
